// File: sfe_pkg.sv
/*
  Shared types and constants for the serial EEPROM slave front end.
  Assumes a system clock much faster than the serial clock, so that
  every pin edge can be found by sampling.
*/
`default_nettype none

package sfe_pkg;

  // Pin bundle width, byte width and counter widths
  localparam int unsigned PIN_W       = 5;
  localparam int unsigned BITS_BYTE   = 8;
  localparam int unsigned BIT_CNT_W   = 3;
  localparam int unsigned BYTE_CNT_W  = 8;

  // Counter values
  localparam logic [BIT_CNT_W-1:0]  BIT_FIRST  = 3'h0;
  localparam logic [BIT_CNT_W-1:0]  BIT_LAST   = 3'h7;
  localparam logic [BIT_CNT_W-1:0]  BIT_STEP   = 3'h1;
  localparam logic [BYTE_CNT_W-1:0] BYTE_NONE  = 8'h00;
  localparam logic [BYTE_CNT_W-1:0] BYTE_STEP  = 8'h01;
  localparam logic [BYTE_CNT_W-1:0] BYTE_MAX   = 8'hFF;
  localparam logic [BITS_BYTE-1:0]  BYTE_ZERO  = 8'h00;

  // Synchroniser reset image: all pins low, so a select held low
  // through reset never looks like a falling edge
  localparam logic [PIN_W-1:0]      PINS_RESET = 5'h00;

  // Link state
  typedef enum logic [1:0] {
    SFE_IDLE  = 2'b00,
    SFE_SEL   = 2'b01,
    SFE_PAUSE = 2'b10
  } sfe_state_t;

  // Raw or synchronised pin levels
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic hold_n;
    logic wp_n;
  } sfe_pins_t;

  // Received byte towards the command layer
  typedef struct packed {
    logic                  valid;
    logic [BYTE_CNT_W-1:0] index;
    logic [BITS_BYTE-1:0]  data;
  } sfe_rx_t;

endpackage

`default_nettype wire

// File: sfe_pin_sync.sv
/*
  Two-stage synchronisers for the serial pins, plus one history stage
  for edge detection.
  Assumes every input is asynchronous to i_clock.
*/
`timescale 1ns/1ns
`default_nettype none

module sfe_pin_sync
  import sfe_pkg::*;
(
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // Pins
  input  wire logic [PIN_W-1:0] i_raw,
  // Synchronised level and its previous sample
  output logic      [PIN_W-1:0] o_level,
  output logic      [PIN_W-1:0] o_prev
);

  logic [PIN_W-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < PIN_W; g++) begin : g_bit
      // First stage feeds only the second
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          meta[g]    <= PINS_RESET[g];
          o_level[g] <= PINS_RESET[g];
          o_prev[g]  <= PINS_RESET[g];
        end else begin
          meta[g]    <= i_raw[g];
          o_level[g] <= meta[g];
          o_prev[g]  <= o_level[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: sfe_front_end.sv
/*
  Serial slave front end of a byte-wide serial EEPROM: select
  qualification, pause handling, bit and byte shifting, output drive,
  power state and the volatile status flags.
  Assumes a command layer beside it that decodes bytes, says when the
  output phase runs and when a whole write command was seen, and ends
  internal write cycles. The serial clock must run well below a
  quarter of i_clock.
*/
`timescale 1ns/1ns
`default_nettype none

module sfe_front_end
  import sfe_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_rst,
  // Serial pins
  input  wire logic                  i_sclk,
  input  wire logic                  i_cs_n,
  input  wire logic                  i_mosi,
  input  wire logic                  i_hold_n,
  input  wire logic                  i_wp_n,
  output logic                       o_miso,
  output logic                       o_miso_oe,
  // Received bytes
  output sfe_rx_t                    o_rx,
  output logic     [BIT_CNT_W-1:0]   o_bit_count,
  output logic     [BYTE_CNT_W-1:0]  o_byte_count,
  // Output phase from the command layer
  input  wire logic                  i_out_phase,
  input  wire logic [BITS_BYTE-1:0]  i_tx_byte,
  output logic                       o_tx_taken,
  // Frame and write control
  input  wire logic                  i_write_cmd_ok,
  input  wire logic                  i_write_done,
  input  wire logic                  i_wel_set,
  input  wire logic                  i_wel_clr,
  output logic                       o_frame_end,
  output logic                       o_frame_whole,
  output logic                       o_write_start,
  // Status
  output logic                       o_write_enable_latch,
  output logic                       o_write_busy_flag,
  output logic                       o_wp_n_level,
  output logic                       o_selected,
  output logic                       o_paused,
  output logic                       o_active,
  output logic                       o_standby
);

  sfe_pins_t pins_raw;
  sfe_pins_t pins_now;
  sfe_pins_t pins_prev;

  sfe_state_t state;
  sfe_state_t next_state;

  logic [BIT_CNT_W-1:0]  bit_cnt;
  logic [BIT_CNT_W-1:0]  next_bit_cnt;
  logic [BYTE_CNT_W-1:0] byte_cnt;
  logic [BYTE_CNT_W-1:0] next_byte_cnt;
  logic [BITS_BYTE-2:0]  rx_shift;
  logic [BIT_CNT_W-1:0]  tx_cnt;
  logic [BIT_CNT_W-1:0]  next_tx_cnt;
  logic [BITS_BYTE-1:0]  tx_shift;
  logic [BITS_BYTE-1:0]  next_tx_shift;
  logic                  next_miso;
  logic                  driving;
  logic                  next_driving;
  sfe_rx_t               next_rx;
  logic                  next_wel;
  logic                  next_busy;

  assign pins_raw = '{sclk: i_sclk, cs_n: i_cs_n, mosi: i_mosi, hold_n: i_hold_n, wp_n: i_wp_n};

  sfe_pin_sync u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_raw   (pins_raw),
    .o_level (pins_now),
    .o_prev  (pins_prev)
  );

  // Edge decode, shared by the clock, select and pause pins
  function automatic logic rose(input logic now_v, input logic prev_v);
    return now_v & ~prev_v;
  endfunction

  function automatic logic fell(input logic now_v, input logic prev_v);
    return ~now_v & prev_v;
  endfunction

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic hold_fall;
  logic hold_rise;
  logic clk_low;
  logic in_sel;
  logic in_idle;
  logic shift_en;
  logic out_en;
  logic byte_done;
  logic frame_end;
  logic tx_load;
  logic frame_whole;
  logic write_go;

  // Edge decode on synchronised pins
  assign sclk_rise = rose(pins_now.sclk, pins_prev.sclk);
  assign sclk_fall = fell(pins_now.sclk, pins_prev.sclk);
  assign cs_fall   = fell(pins_now.cs_n, pins_prev.cs_n);
  assign cs_rise   = rose(pins_now.cs_n, pins_prev.cs_n);
  assign hold_fall = fell(pins_now.hold_n, pins_prev.hold_n);
  assign hold_rise = rose(pins_now.hold_n, pins_prev.hold_n);
  // Level, not edge: the pause pin may move long after the clock fell
  assign clk_low   = ~pins_now.sclk;

  assign in_sel    = (state == SFE_SEL);
  assign in_idle   = (state == SFE_IDLE);

  assign shift_en  = in_sel & sclk_rise;
  assign out_en    = in_sel & sclk_fall & i_out_phase;
  assign byte_done = shift_en & (bit_cnt == BIT_LAST);
  assign frame_end = cs_rise & ~in_idle;
  assign tx_load   = out_en & (tx_cnt == BIT_FIRST);

  // Whole bytes only; a stray bit spoils the frame
  assign frame_whole = (bit_cnt == BIT_FIRST) & (byte_cnt != BYTE_NONE);
  assign write_go    = frame_end & frame_whole & i_write_cmd_ok & ~o_write_busy_flag;

  // Link state machine
  always_comb begin
    next_state = state;
    unique case (state)
      SFE_IDLE: begin
        if (cs_fall) begin
          next_state = SFE_SEL;
        end
      end
      SFE_SEL: begin
        if (cs_rise) begin
          next_state = SFE_IDLE;
        end else if (hold_fall & clk_low) begin
          next_state = SFE_PAUSE;
        end
      end
      SFE_PAUSE: begin
        if (cs_rise) begin
          next_state = SFE_IDLE;
        end else if (hold_rise & clk_low) begin
          next_state = SFE_SEL;
        end
      end
      default: begin
        next_state = SFE_IDLE;
      end
    endcase
  end

  // Input shifting and counting
  always_comb begin
    next_bit_cnt  = bit_cnt;
    next_byte_cnt = byte_cnt;
    if (frame_end | cs_fall) begin
      next_bit_cnt  = BIT_FIRST;
      next_byte_cnt = BYTE_NONE;
    // Count on rising edges from select
    end else if (shift_en) begin
      next_bit_cnt = bit_cnt + BIT_STEP;
      // Saturates so a long page never looks empty
      if (byte_done && (byte_cnt != BYTE_MAX)) begin
        next_byte_cnt = byte_cnt + BYTE_STEP;
      end
    end
  end

  // Received byte, most significant bit first
  always_comb begin
    next_rx = o_rx;
    next_rx.valid = 1'b0;
    if (byte_done) begin
      next_rx.valid = 1'b1;
      next_rx.index = byte_cnt;
      next_rx.data  = {rx_shift, pins_now.mosi};
    end
  end

  // Output shifting on falling edges
  always_comb begin
    next_tx_cnt   = tx_cnt;
    next_tx_shift = tx_shift;
    next_miso     = o_miso;
    next_driving  = driving;
    if (frame_end | cs_fall | ~i_out_phase) begin
      next_tx_cnt  = BIT_FIRST;
      next_driving = 1'b0;
    // Drive on falling edges in output phase
    end else if (out_en) begin
      next_tx_cnt  = tx_cnt + BIT_STEP;
      next_driving = 1'b1;
      // Send MSB first
      // Next byte is taken on the ninth fall; have it ready
      if (tx_load) begin
        next_miso     = i_tx_byte[BITS_BYTE-1];
        next_tx_shift = {i_tx_byte[BITS_BYTE-2:0], 1'b0};
      end else begin
        next_miso     = tx_shift[BITS_BYTE-1];
        next_tx_shift = {tx_shift[BITS_BYTE-2:0], 1'b0};
      end
    end
  end

  // Volatile status flags; set beats clear in the same cycle
  always_comb begin
    next_wel  = o_write_enable_latch;
    next_busy = o_write_busy_flag;
    if (i_wel_set) begin
      next_wel = 1'b1;
    end else if (i_wel_clr) begin
      next_wel = 1'b0;
    end
    // Busy holds until the command layer ends the write
    if (write_go) begin
      next_busy = 1'b1;
    end else if (i_write_done) begin
      next_busy = 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state                <= SFE_IDLE;
      o_write_enable_latch <= 1'b0;
      o_write_busy_flag    <= 1'b0;
    end else begin
      state                <= next_state;
      o_write_enable_latch <= next_wel;
      o_write_busy_flag    <= next_busy;
    end
  end

  // Receive counters and byte register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt  <= BIT_FIRST;
      byte_cnt <= BYTE_NONE;
      rx_shift <= BYTE_ZERO[BITS_BYTE-2:0];
      o_rx     <= '{valid: 1'b0, index: BYTE_NONE, data: BYTE_ZERO};
    end else begin
      bit_cnt  <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      o_rx     <= next_rx;
      if (shift_en) begin
        rx_shift <= {rx_shift[BITS_BYTE-3:0], pins_now.mosi};
      end
    end
  end

  // Transmit path registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tx_cnt     <= BIT_FIRST;
      tx_shift   <= BYTE_ZERO;
      o_miso     <= 1'b0;
      driving    <= 1'b0;
      o_tx_taken <= 1'b0;
    end else begin
      tx_cnt     <= next_tx_cnt;
      tx_shift   <= next_tx_shift;
      o_miso     <= next_miso;
      driving    <= next_driving;
      o_tx_taken <= tx_load & ~frame_end;
    end
  end

  // Frame pulses, sampled protect level
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_frame_end   <= 1'b0;
      o_frame_whole <= 1'b0;
      o_write_start <= 1'b0;
      o_wp_n_level  <= 1'b0;
    end else begin
      o_frame_end   <= frame_end;
      o_frame_whole <= frame_end & frame_whole;
      o_write_start <= write_go;
      o_wp_n_level  <= pins_now.wp_n;
    end
  end

  assign o_miso_oe    = driving & in_sel & i_out_phase;

  // Power state from select and busy flag
  assign o_active     = ~in_idle;
  assign o_standby    = in_idle & ~o_write_busy_flag;

  assign o_selected   = ~in_idle;
  assign o_paused     = (state == SFE_PAUSE);
  assign o_bit_count  = bit_cnt;
  assign o_byte_count = byte_cnt;

endmodule

`default_nettype wire

// File: sfe_master_model.sv
/*
  Behavioural bus master for the serial EEPROM front end.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module sfe_master_model (
  // Clock and return data
  input  wire logic i_clock,
  input  wire logic i_miso,
  // Pins towards the device
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi,
  output logic      o_hold_n
);
  logic cpol;
  // Select low through power-up, as a floating bus may leave it
  initial begin
    cpol = 0; o_sclk = 0; o_cs_n = 0; o_mosi = 0; o_hold_n = 1;
  end
  task automatic open_frame(input logic mode);
    @(negedge i_clock);
    cpol = mode; o_sclk = mode; #63;
    o_cs_n = 0; #63;
  endtask
  task automatic shift(input logic [7:0] d, input int n, output logic [7:0] q);
    q = '0;
    for (int i = 0; i < n; i++) begin
      o_sclk = 0; o_mosi = d[7-i]; #62;
      o_sclk = 1; q = {q[6:0], i_miso}; #63;
    end
  endtask
  task automatic hold(input logic lvl);
    o_sclk = 0; #62;
    o_hold_n = lvl; #63;
  endtask
  // Released data line shows the inverse, not the last bit
  task automatic close_frame;
    o_sclk = 0; #62;
    o_cs_n = 1; o_mosi = ~o_mosi; #63;
    o_sclk = cpol;
  endtask
endmodule
`default_nettype wire

// File: sfe_front_end_sva.sv
/*
  Port checker for sfe_front_end.
  Assumes binding into every sfe_front_end instance.
*/
`timescale 1ns/1ns
`default_nettype none
module sfe_front_end_sva
  import sfe_pkg::*;
(
  // Clock, reset, inputs
  input wire logic                  i_clock,
  input wire logic                  i_rst,
  input wire logic                  i_cs_n,
  input wire logic                  i_out_phase,
  // Outputs watched
  input wire logic                  o_miso_oe,
  input wire sfe_rx_t               o_rx,
  input wire logic [BIT_CNT_W-1:0]  o_bit_count,
  input wire logic [BYTE_CNT_W-1:0] o_byte_count,
  input wire logic                  o_frame_end,
  input wire logic                  o_frame_whole,
  input wire logic                  o_write_start,
  input wire logic                  o_write_busy_flag,
  input wire logic                  o_selected,
  input wire logic                  o_paused,
  input wire logic                  o_active,
  input wire logic                  o_standby
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_cs_high; i_cs_n [*5]; endsequence
  sequence s_held_pause; o_paused && $past(o_paused); endsequence
  property p_standby; o_standby == (!o_active && !o_write_busy_flag); endproperty
  a_standby: assert property (p_standby) else $error("standby wrong");
  property p_oe; o_miso_oe |-> o_selected && !o_paused && i_out_phase; endproperty
  a_oe: assert property (p_oe) else $error("output drive wrong");
  property p_desel; s_cs_high |-> !o_selected && !o_miso_oe; endproperty
  a_desel: assert property (p_desel) else $error("select high ignored");
  property p_wstart; o_write_start |-> ##[0:1] o_write_busy_flag; endproperty
  a_wstart: assert property (p_wstart) else $error("busy not set");
  property p_whole; o_frame_whole |-> o_frame_end; endproperty
  a_whole: assert property (p_whole) else $error("whole without end");
  property p_valid; o_rx.valid |=> !o_rx.valid; endproperty
  a_valid: assert property (p_valid) else $error("byte pulse long");
  property p_freeze; s_held_pause |-> $stable(o_bit_count) && $stable(o_byte_count); endproperty
  a_freeze: assert property (p_freeze) else $error("counts moved in pause");
  property p_psel; o_paused |-> o_selected && !o_miso_oe; endproperty
  a_psel: assert property (p_psel) else $error("pause unselected");
endmodule
bind sfe_front_end sfe_front_end_sva u_sva (.*);
`default_nettype wire

// File: testbench.sv
/*
  Self-checking bench for sfe_front_end with a master model.
  Assumes the checker is bound by its own file.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sfe_pkg::*;
  logic i_clock, i_rst, sclk, cs_n, mosi, hold_n, wp_n, miso, oe, miso_w;
  logic out_phase, cmd_ok, wdone, wset, wclr, wstart, write_enable_latch, busy, sel, paused, stby, taken, wpl;
  logic [7:0]  tx, q, b[3];
  logic [31:0] seed;
  sfe_rx_t     rx;
  logic [7:0]  rxq[$];
  int          n_errors, n_compared, ws_cnt, tk_cnt;
  assign miso_w = oe ? miso : ~miso;
  sfe_front_end u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_mosi(mosi), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_miso(miso), .o_miso_oe(oe),
    .o_rx(rx), .o_bit_count(), .o_byte_count(), .i_out_phase(out_phase), .i_tx_byte(tx),
    .o_tx_taken(taken), .i_write_cmd_ok(cmd_ok), .i_write_done(wdone), .i_wel_set(wset),
    .i_wel_clr(wclr), .o_frame_end(), .o_frame_whole(), .o_write_start(wstart),
    .o_write_enable_latch(write_enable_latch), .o_write_busy_flag(busy), .o_wp_n_level(wpl),
    .o_selected(sel), .o_paused(paused), .o_active(), .o_standby(stby));
  sfe_master_model u_master (.i_clock(i_clock), .i_miso(miso_w), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_mosi(mosi), .o_hold_n(hold_n));
  initial begin
    i_clock = 0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    if (rx.valid === 1'b1) rxq.push_back(rx.data);
    if (wstart === 1'b1) ws_cnt++;
    if (taken === 1'b1) tk_cnt++;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic exp_start(input int nbits, input logic ok);
    return ok && (nbits % 8 == 0) && nbits > 0;
  endfunction
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_idle;
    int k;
    for (k = 0; k < 50 && sel !== 1'b0; k++) @(negedge i_clock);
    if (k == 50) begin
      n_errors++;
      final_report();
    end
    repeat (4) @(negedge i_clock);
  endtask
  task automatic pause_junk;
    u_master.hold(0);
    check("paused", paused, 1);
    check("oe paused", oe, 0);
    u_master.shift(rnd(), 3, q);
  endtask
  // Write-like frame; pz 1 pauses mid-byte, pz 2 deselects in pause
  task automatic frame(input logic mode, input int nbits, input logic ok, input int pz);
    int st;
    @(negedge i_clock);
    cmd_ok = ok;
    wp_n = seed[3];
    st = ws_cnt;
    rxq.delete();
    u_master.open_frame(mode);
    check("selected", sel, 1);
    check("wp level", wpl, wp_n);
    for (int i = 0; i < 3; i++) begin
      b[i] = rnd();
      if (pz == 1 && i == 2) begin
        u_master.shift(b[i], 4, q);
        pause_junk();
        u_master.hold(1);
        check("resumed", paused, 0);
        u_master.shift(b[i] << 4, 4, q);
      end else u_master.shift(b[i], 8, q);
    end
    u_master.shift(rnd(), nbits - 24, q);
    check("oe write", oe, 0);
    if (pz == 2) pause_junk();
    u_master.close_frame();
    if (pz == 2) begin
      check("pause idle", paused, 0);
      u_master.hold(1);
    end
    wait_idle();
    check("write start", ws_cnt - st, exp_start(nbits, ok));
    check("rx count", rxq.size(), nbits / 8);
    for (int i = 0; i < 3; i++) check("rx byte", rxq[i], b[i]);
    check("latch kept", write_enable_latch, 1);
    if (exp_start(nbits, ok)) begin
      check("standby busy", stby, 0);
      @(negedge i_clock) wdone = 1;
      @(negedge i_clock) wdone = 0;
      check("busy done", busy, 0);
    end
  endtask
  task automatic read_frame(input logic mode);
    int st;
    int tk;
    @(negedge i_clock);
    // Reads never ask for a write cycle
    cmd_ok = 0;
    st = ws_cnt;
    tk = tk_cnt;
    u_master.open_frame(mode);
    u_master.shift(rnd(), 8, q);
    @(negedge i_clock);
    tx = rnd();
    out_phase = 1;
    u_master.shift(rnd(), 8, q);
    check("read byte", q, tx);
    check("tx taken", tk_cnt - tk, 1);
    u_master.close_frame();
    wait_idle();
    check("oe deselect", oe, 0);
    check("read write start", ws_cnt - st, 0);
    out_phase = 0;
  endtask
  initial begin
    n_errors = 0; n_compared = 0; ws_cnt = 0; seed = 32'hd7aa;
    tk_cnt = 0;
    i_rst = 1; wp_n = 1; out_phase = 0; cmd_ok = 0; wdone = 0; wset = 0; wclr = 0; tx = 0;
    repeat (10) @(negedge i_clock);
    check("reset standby", stby, 1);
    check("reset oe", oe, 0);
    i_rst = 0;
    repeat (20) @(negedge i_clock);
    u_master.shift(rnd(), 8, q);
    check("early select", sel, 0);
    check("early rx", rxq.size(), 0);
    u_master.close_frame();
    check("latch reset", write_enable_latch, 0);
    check("busy reset", busy, 0);
    @(negedge i_clock) wset = 1;
    @(negedge i_clock) wset = 0;
    for (int m = 0; m < 2; m++) begin
      frame(m, 24, 1, 0);
      frame(m, 27, 1, 1);
      frame(m, 32, 0, 0);
      frame(m, 24, 1, 2);
      read_frame(m);
    end
    @(negedge i_clock) wclr = 1;
    @(negedge i_clock) wclr = 0;
    check("latch clear", write_enable_latch, 0);
    check("standby idle", stby, 1);
    @(negedge i_clock) wset = 1;
    @(negedge i_clock) wset = 0;
    check("latch set", write_enable_latch, 1);
    i_rst = 1;
    @(negedge i_clock) i_rst = 0;
    check("latch mid reset", write_enable_latch, 0);
    check("standby mid reset", stby, 1);
    repeat (4) @(negedge i_clock);
    check("select mid reset", sel, 0);
    final_report();
  end
endmodule
`default_nettype wire
